// File: trm_pkg.sv
// Register map, field positions and timing constants for the test/reset/monitor register bank
package trm_pkg;
    // Register indices; byte address is four times the index
    localparam logic [4:0] IDX_CTRL     = 5'h00;
    localparam logic [4:0] IDX_STAT     = 5'h01;
    localparam logic [4:0] IDX_CMDPTR   = 5'h02;
    localparam logic [4:0] IDX_POLL     = 5'h03;
    localparam logic [4:0] IDX_BITRES   = 5'h04;
    localparam logic [4:0] IDX_CURCMD   = 5'h05;
    localparam logic [4:0] IDX_ILOGPTR  = 5'h06;
    localparam logic [4:0] IDX_UIEN     = 5'h07;
    localparam logic [4:0] IDX_UIFLG    = 5'h08;
    localparam logic [4:0] IDX_RTADDR   = 5'h0a;
    localparam logic [4:0] IDX_BITSTART = 5'h0b;
    localparam logic [4:0] IDX_PRST     = 5'h0c;
    localparam logic [4:0] IDX_TTRST    = 5'h0d;
    localparam logic [4:0] IDX_MODE     = 5'h0e;
    localparam logic [4:0] IDX_RSVD     = 5'h0f;
    localparam logic [4:0] IDX_MONLO    = 5'h10;
    localparam logic [4:0] IDX_MONHI    = 5'h11;
    localparam logic [4:0] IDX_TTVAL    = 5'h12;

    // Field positions
    localparam int CTRL_SEL_BIT      = 10;
    localparam int STAT_TEST_BIT     = 15;
    localparam int STAT_BIT_BIT      = 9;
    localparam int STAT_RESET_BIT    = 8;
    localparam int STAT_SEL_BIT      = 7;
    localparam int RES_PRI_BIT       = 14;
    localparam int RES_SEC_BIT       = 15;
    localparam int MODE_MON_BIT      = 15;
    localparam int MODE_ALL_BIT      = 14;
    localparam int MODE_DECL_BIT     = 13;
    localparam logic [15:0] MODE_MASK = 16'he000;
    localparam logic [15:0] CTRL_MASK = 16'h1fff;
    localparam logic [15:0] UIEN_MASK = 16'h01ff;

    // Reset values
    localparam logic [15:0] REG_RST  = 16'h0000;
    localparam logic [7:0]  TT_RST   = 8'h00;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Timing
    localparam int CLK_MHZ       = 100;
    localparam int BIT_TIME_US   = 100;
    localparam int BIT_CYCLES    = BIT_TIME_US * CLK_MHZ;
    localparam int PRST_TIME_NS  = 1000;
    localparam int CLK_NS        = 10;
    localparam int PRST_CYCLES   = PRST_TIME_NS / CLK_NS - 1;
    localparam int TICK_TIME_US  = 64;
    localparam int TICK_CYCLES   = TICK_TIME_US * CLK_MHZ;

    typedef enum logic [2:0] {
        TRM_IDLE = 3'b001,
        TRM_PRST = 3'b010,
        TRM_TEST = 3'b100
    } trm_state_t;
endpackage

// File: trm_regs.sv
// Test, reset and monitor register bank of a redundant serial bus terminal, AXI4-Lite slave
// Function
// - Any write to self-test start while idle (no test or programmed reset running) runs built-in test for 100 us.
// - Status register shows self-test in progress while it runs.
// - Test failure shows in result register and terminal-fail pin.
// - Loopback into both decoders; bit 14 primary fail, bit 15 secondary.
// - Terminal ignores bus commands while the self-test runs.
// - Any write to programmed reset while idle (no test or programmed reset running) resets codec/protocol in under 1 us.
// - Programmed reset halts command processing, keeps registers intact.
// - Any write to timer reset clears time tag, counting resumes at once.
// - Eight-bit free-running time tag advances every 64 us.
// - Mode bit 15 enables monitor only when control bit 10 is zero.
// - Mode bit 14 monitors all terminal addresses.
// - Mode bit 13 monitors declared terminals; host sets 14 or 13.
// - Low filter bit n enables terminal address n, 0 to 15.
// - High filter bit n enables terminal address n+16.
// - Filter bits are independent; any combination may be monitored.
// - Terminal address captured from pins at master reset; software may overwrite.
`timescale 1ns/1ps
module trm_regs #(
    parameter int BIT_CYC  = trm_pkg::BIT_CYCLES,   // Self-test length in cycles
    parameter int TICK_CYC = trm_pkg::TICK_CYCLES   // Time-tag period in cycles
) (
    input  wire logic        mclk_i,               // 100 MHz clock
    input  wire logic        rst_n_i,              // Master reset, async, active low
    input  wire logic [7:0]  s_axi_awaddr_i,       // Write address
    input  wire logic        s_axi_awvalid_i,      // Write address valid
    output logic             s_axi_awready_o,      // Write address ready
    input  wire logic [31:0] s_axi_wdata_i,        // Write data
    input  wire logic [3:0]  s_axi_wstrb_i,        // Write strobes
    input  wire logic        s_axi_wvalid_i,       // Write data valid
    output logic             s_axi_wready_o,       // Write data ready
    output logic [1:0]       s_axi_bresp_o,        // Write response
    output logic             s_axi_bvalid_o,       // Write response valid
    input  wire logic        s_axi_bready_i,       // Write response ready
    input  wire logic [7:0]  s_axi_araddr_i,       // Read address
    input  wire logic        s_axi_arvalid_i,      // Read address valid
    output logic             s_axi_arready_o,      // Read address ready
    output logic [31:0]      s_axi_rdata_o,        // Read data
    output logic [1:0]       s_axi_rresp_o,        // Read response
    output logic             s_axi_rvalid_o,       // Read data valid
    input  wire logic        s_axi_rready_i,       // Read data ready
    input  wire logic [4:0]  terminal_address_inputs_i, // Address pins, async
    input  wire logic        primary_channel_fail_i,    // Loopback mismatch on primary decoder
    input  wire logic        secondary_channel_fail_i,  // Loopback mismatch on secondary decoder
    input  wire logic        bus_command_i,        // Command strobe from decoder, same clock
    output logic             terminal_fail_out_o,  // Self-test failed
    output logic             loopback_en_o,        // Encoder wrapped into both decoders
    output logic             codec_reset_o,        // Codec/protocol reset, active high
    output logic             cmd_accept_o,         // Command accepted by terminal
    output logic             cmd_halt_o,           // Command processing halted
    output logic             monitor_en_o,         // Monitor mode active
    output logic [31:0]      monitor_sel_o,        // Per-address monitor enables
    output logic [4:0]       terminal_address_o,   // Current terminal address
    output logic [7:0]       time_tag_o            // Time-tag value
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [4:0] reg_idx(input logic [7:0] a);
        reg_idx = a[6:2];
    endfunction

    function automatic logic mapped(input logic [4:0] i);
        mapped = (i <= trm_pkg::IDX_TTVAL) && (i != 5'h09) && (i != trm_pkg::IDX_RSVD);
    endfunction

    function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [15:0] d,
                                               input logic [1:0] en, input logic [15:0] msk);
        lane_merge[7:0]  = en[0] ? (d[7:0] & msk[7:0]) : old[7:0];
        lane_merge[15:8] = en[1] ? (d[15:8] & msk[15:8]) : old[15:8];
    endfunction

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [4:0] addr_s1, addr_s2;
    logic       sync_done;

    // No reset, so the pins are already through both stages when reset lifts
    always_ff @(posedge mclk_i) begin
        addr_s1 <= terminal_address_inputs_i;
        addr_s2 <= addr_s1;
    end

    // ------------------------------------------------------------
    // Bus slave state and registers
    // ------------------------------------------------------------
    logic        aw_held, w_held, aw_rdy, w_rdy, bvalid, arready, rvalid;
    logic [4:0]  aw_idx;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [15:0] ctrl, cmdptr, poll, ilogptr, uien, mode, monlo, monhi;
    logic [4:0]  rtaddr;
    logic [15:0] bitres;
    logic        tfail;

    logic        next_aw_held, next_w_held, next_aw_rdy, next_w_rdy, next_bvalid, next_arready, next_rvalid;
    logic [4:0]  next_aw_idx;
    logic [31:0] next_wdata, next_rdata;
    logic [3:0]  next_wstrb;
    logic [1:0]  next_bresp, next_rresp;
    logic [15:0] next_ctrl, next_cmdptr, next_poll, next_ilogptr, next_uien, next_mode;
    logic [15:0] next_monlo, next_monhi;
    logic [4:0]  next_rtaddr;
    logic        next_sync_done;
    logic        wr_go;
    logic        bit_start_wr, prst_wr, ttrst_wr;

    // Engine state, read by the register logic
    trm_pkg::trm_state_t state, next_state;
    logic [13:0] cnt, next_cnt;
    logic [12:0] tick, next_tick;
    logic [7:0]  ttag, next_ttag;
    logic        halt, next_halt;
    logic        pfail, sfail, next_pfail, next_sfail;
    logic [15:0] next_bitres;
    logic        next_tfail;

    always_comb begin
        next_aw_held = aw_held;
        next_w_held  = w_held;
        next_aw_idx  = aw_idx;
        next_wdata   = wdata;
        next_wstrb   = wstrb;
        next_bvalid  = bvalid;
        next_bresp   = bresp;
        next_arready = 1'b0;
        next_rvalid  = rvalid;
        next_rdata   = rdata;
        next_rresp   = rresp;
        next_ctrl    = ctrl;
        next_cmdptr  = cmdptr;
        next_poll    = poll;
        next_ilogptr = ilogptr;
        next_uien    = uien;
        next_mode    = mode;
        next_monlo   = monlo;
        next_monhi   = monhi;
        next_rtaddr  = rtaddr;
        next_sync_done = 1'b1;
        bit_start_wr = 1'b0;
        prst_wr      = 1'b0;
        ttrst_wr     = 1'b0;
        if (s_axi_awvalid_i && aw_rdy) begin
            next_aw_held = 1'b1;
            next_aw_idx  = reg_idx(s_axi_awaddr_i);
        end
        if (s_axi_wvalid_i && w_rdy) begin
            next_w_held = 1'b1;
            next_wdata  = s_axi_wdata_i;
            next_wstrb  = s_axi_wstrb_i;
        end
        wr_go = aw_held && w_held && !bvalid;
        if (wr_go) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = mapped(aw_idx) ? trm_pkg::RESP_OKAY : trm_pkg::RESP_SLVERR;
            case (aw_idx)
                trm_pkg::IDX_CTRL:    next_ctrl    = lane_merge(ctrl, wdata[15:0], wstrb[1:0], trm_pkg::CTRL_MASK);
                trm_pkg::IDX_CMDPTR:  next_cmdptr  = lane_merge(cmdptr, wdata[15:0], wstrb[1:0], 16'hffff);
                trm_pkg::IDX_POLL:    next_poll    = lane_merge(poll, wdata[15:0], wstrb[1:0], 16'hffff);
                trm_pkg::IDX_ILOGPTR: next_ilogptr = lane_merge(ilogptr, wdata[15:0], wstrb[1:0], 16'hffff);
                trm_pkg::IDX_UIEN:    next_uien    = lane_merge(uien, wdata[15:0], wstrb[1:0], trm_pkg::UIEN_MASK);
                trm_pkg::IDX_RTADDR: if (wstrb[0]) next_rtaddr = wdata[4:0];
                trm_pkg::IDX_BITSTART: bit_start_wr = 1'b1;
                trm_pkg::IDX_PRST: prst_wr = 1'b1;
                trm_pkg::IDX_TTRST: ttrst_wr = 1'b1;
                trm_pkg::IDX_MODE:    next_mode    = lane_merge(mode, wdata[15:0], wstrb[1:0], trm_pkg::MODE_MASK);
                trm_pkg::IDX_MONLO:   next_monlo   = lane_merge(monlo, wdata[15:0], wstrb[1:0], 16'hffff);
                trm_pkg::IDX_MONHI:   next_monhi   = lane_merge(monhi, wdata[15:0], wstrb[1:0], 16'hffff);
                default: ;
            endcase
        end
        if (bvalid && s_axi_bready_i) next_bvalid = 1'b0;
        // capture address pins after master reset release
        if (!sync_done) next_rtaddr = addr_s2;
        if (s_axi_arvalid_i && !arready && !rvalid) begin
            next_arready = 1'b1;
            next_rvalid  = 1'b1;
            next_rresp   = mapped(reg_idx(s_axi_araddr_i)) ? trm_pkg::RESP_OKAY : trm_pkg::RESP_SLVERR;
            next_rdata   = 32'h0000_0000;
            case (reg_idx(s_axi_araddr_i))
                trm_pkg::IDX_CTRL:    next_rdata[15:0] = ctrl;
                trm_pkg::IDX_STAT: begin
                    next_rdata[trm_pkg::STAT_TEST_BIT]  = (state == trm_pkg::TRM_TEST);
                    next_rdata[trm_pkg::STAT_BIT_BIT]   = tfail;
                    next_rdata[trm_pkg::STAT_RESET_BIT] = (state == trm_pkg::TRM_PRST);
                    next_rdata[trm_pkg::STAT_SEL_BIT]   = ctrl[trm_pkg::CTRL_SEL_BIT];
                end
                trm_pkg::IDX_CMDPTR:  next_rdata[15:0] = cmdptr;
                trm_pkg::IDX_POLL:    next_rdata[15:0] = poll;
                trm_pkg::IDX_BITRES:  next_rdata[15:0] = bitres;
                trm_pkg::IDX_ILOGPTR: next_rdata[15:0] = ilogptr;
                trm_pkg::IDX_UIEN:    next_rdata[15:0] = uien;
                trm_pkg::IDX_RTADDR:  next_rdata[4:0]  = rtaddr;
                trm_pkg::IDX_MODE:    next_rdata[15:0] = mode;
                trm_pkg::IDX_MONLO:   next_rdata[15:0] = monlo;
                trm_pkg::IDX_MONHI:   next_rdata[15:0] = monhi;
                trm_pkg::IDX_TTVAL:   next_rdata[7:0]  = ttag;
                default: ;
            endcase
        end
        if (rvalid && s_axi_rready_i) next_rvalid = 1'b0;
        next_aw_rdy = !next_aw_held;
        next_w_rdy  = !next_w_held;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_held <= 1'b0;
            aw_rdy  <= 1'b0;
            w_rdy   <= 1'b0;
            w_held  <= 1'b0;
            aw_idx  <= 5'h00;
            wdata   <= 32'h0000_0000;
            wstrb   <= 4'h0;
            bvalid  <= 1'b0;
            bresp   <= trm_pkg::RESP_OKAY;
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= trm_pkg::RESP_OKAY;
            ctrl    <= trm_pkg::REG_RST;
            cmdptr  <= trm_pkg::REG_RST;
            poll    <= trm_pkg::REG_RST;
            ilogptr <= trm_pkg::REG_RST;
            uien    <= trm_pkg::REG_RST;
            mode    <= trm_pkg::REG_RST;
            monlo   <= trm_pkg::REG_RST;
            monhi   <= trm_pkg::REG_RST;
            rtaddr  <= 5'h00;
            sync_done <= 1'b0;
        end else begin
            aw_held <= next_aw_held;
            aw_rdy  <= next_aw_rdy;
            w_rdy   <= next_w_rdy;
            w_held  <= next_w_held;
            aw_idx  <= next_aw_idx;
            wdata   <= next_wdata;
            wstrb   <= next_wstrb;
            bvalid  <= next_bvalid;
            bresp   <= next_bresp;
            arready <= next_arready;
            rvalid  <= next_rvalid;
            rdata   <= next_rdata;
            rresp   <= next_rresp;
            ctrl    <= next_ctrl;
            cmdptr  <= next_cmdptr;
            poll    <= next_poll;
            ilogptr <= next_ilogptr;
            uien    <= next_uien;
            mode    <= next_mode;
            monlo   <= next_monlo;
            monhi   <= next_monhi;
            rtaddr  <= next_rtaddr;
            sync_done <= next_sync_done;
        end
    end

    // ------------------------------------------------------------
    // Self-test, programmed reset and time tag
    // ------------------------------------------------------------
    always_comb begin
        next_state  = state;
        next_cnt    = cnt;
        next_halt   = halt;
        next_pfail  = pfail;
        next_sfail  = sfail;
        next_bitres = bitres;
        next_tfail  = tfail;
        next_tick   = tick + 13'h0001;
        next_ttag   = ttag;
        case (state)
            trm_pkg::TRM_IDLE: begin
                if (prst_wr) begin
                    next_state = trm_pkg::TRM_PRST;
                    next_cnt   = 14'h0000;
                end else if (bit_start_wr) begin
                    // Test loops over both channels; earlier result is discarded
                    next_state = trm_pkg::TRM_TEST;
                    next_cnt   = 14'h0000;
                    next_pfail = 1'b0;
                    next_sfail = 1'b0;
                end
            end
            // reset pulse shorter than 1 us
            trm_pkg::TRM_PRST: begin
                next_cnt = cnt + 14'h0001;
                next_halt = 1'b1;
                if (cnt == 14'(trm_pkg::PRST_CYCLES - 1)) next_state = trm_pkg::TRM_IDLE;
            end
            trm_pkg::TRM_TEST: begin
                next_cnt = cnt + 14'h0001;
                if (primary_channel_fail_i)   next_pfail = 1'b1;
                if (secondary_channel_fail_i) next_sfail = 1'b1;
                if (cnt == 14'(BIT_CYC - 1)) begin
                    next_state = trm_pkg::TRM_IDLE;
                    next_bitres = trm_pkg::REG_RST;
                    next_bitres[trm_pkg::RES_PRI_BIT] = next_pfail;
                    next_bitres[trm_pkg::RES_SEC_BIT] = next_sfail;
                    next_tfail = next_pfail | next_sfail;
                end
            end
            default: next_state = trm_pkg::TRM_IDLE;
        endcase
        if (ttrst_wr) begin
            next_tick = 13'h0000;
            next_ttag = trm_pkg::TT_RST;
        end else if (tick == 13'(TICK_CYC - 1)) begin
            next_tick = 13'h0000;
            next_ttag = ttag + 8'h01;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state  <= trm_pkg::TRM_IDLE;
            cnt    <= 14'h0000;
            halt   <= 1'b0;
            pfail  <= 1'b0;
            sfail  <= 1'b0;
            bitres <= trm_pkg::REG_RST;
            tfail  <= 1'b0;
            tick   <= 13'h0000;
            ttag   <= trm_pkg::TT_RST;
        end else begin
            state  <= next_state;
            cnt    <= next_cnt;
            halt   <= next_halt;
            pfail  <= next_pfail;
            sfail  <= next_sfail;
            bitres <= next_bitres;
            tfail  <= next_tfail;
            tick   <= next_tick;
            ttag   <= next_ttag;
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            loopback_en_o <= 1'b0;
            codec_reset_o <= 1'b0;
            cmd_accept_o  <= 1'b0;
            monitor_en_o  <= 1'b0;
            monitor_sel_o <= 32'h0000_0000;
        end else begin
            loopback_en_o <= (next_state == trm_pkg::TRM_TEST);
            codec_reset_o <= (next_state == trm_pkg::TRM_PRST);
            cmd_accept_o  <= bus_command_i && !ctrl[trm_pkg::CTRL_SEL_BIT] && !halt && (state != trm_pkg::TRM_TEST);
            monitor_en_o  <= mode[trm_pkg::MODE_MON_BIT] && !ctrl[trm_pkg::CTRL_SEL_BIT];
            // all; declared; low filter 0..15, high filter 16..31
            monitor_sel_o <= mode[trm_pkg::MODE_ALL_BIT] ? 32'hffff_ffff :
                             (mode[trm_pkg::MODE_DECL_BIT] ? {monhi, monlo} : 32'h0000_0000);
        end
    end

    assign cmd_halt_o          = halt;
    assign terminal_fail_out_o = tfail;
    assign terminal_address_o  = rtaddr;
    assign time_tag_o          = ttag;
    assign s_axi_awready_o     = aw_rdy;
    assign s_axi_wready_o      = w_rdy;
    assign s_axi_bvalid_o      = bvalid;
    assign s_axi_bresp_o       = bresp;
    assign s_axi_arready_o     = arready;
    assign s_axi_rvalid_o      = rvalid;
    assign s_axi_rdata_o       = rdata;
    assign s_axi_rresp_o       = rresp;

endmodule

// File: trm_regs_assertions.sv
// Checker bound to the test/reset/monitor register bank
`timescale 1ns/1ps
module trm_chk #(
    parameter int BIT_CYC  = 20,  // Self-test cycles
    parameter int TICK_CYC = 16   // Tag period
) (
    input wire logic       mclk_i,        // Clock
    input wire logic       rst_n_i,       // Reset
    input wire logic       bus_command_i, // Command strobe
    input wire logic       loopback_en_o, // Self-test on
    input wire logic       codec_reset_o, // Codec reset
    input wire logic       cmd_accept_o,  // Accept pulse
    input wire logic       cmd_halt_o,    // Halt level
    input wire logic [7:0] time_tag_o     // Tag
);
    // --------
    // Properties
    // --------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    // Bounds assume the bench's BIT_CYC of 20
    a_test_len: assert property ($rose(loopback_en_o) |-> loopback_en_o[*8] ##[8:16] !loopback_en_o)
        else $error("self-test length wrong");
    a_codec_len: assert property ($rose(codec_reset_o) |-> ##[1:99] !codec_reset_o)
        else $error("codec reset too long");
    a_halt_sticky: assert property (cmd_halt_o |=> cmd_halt_o)
        else $error("halt dropped");
    a_halt_rise: assert property ($rose(cmd_halt_o) |-> codec_reset_o)
        else $error("halt without codec reset");
    a_cmd_block: assert property (bus_command_i && (loopback_en_o || cmd_halt_o) |=> !cmd_accept_o)
        else $error("command taken while blocked");
    a_accept_src: assert property (cmd_accept_o |-> $past(bus_command_i))
        else $error("accept without command");
    a_tag_step: assert property (!$stable(time_tag_o) |-> time_tag_o == $past(time_tag_o) + 8'h01 || time_tag_o == 8'h00)
        else $error("tag jumped");
    a_test_codec: assert property (loopback_en_o |-> !codec_reset_o)
        else $error("test and reset overlap");
endmodule
bind trm_regs trm_chk #(.BIT_CYC(BIT_CYC), .TICK_CYC(TICK_CYC)) u_chk (.mclk_i, .rst_n_i, .bus_command_i,
    .loopback_en_o, .codec_reset_o, .cmd_accept_o, .cmd_halt_o, .time_tag_o);

// File: trm_loop_model.sv
// Loopback decoder model facing the self-test wrap path
`timescale 1ns/1ps
module trm_loop_model (
    input  wire logic       mclk_i,                   // Clock
    input  wire logic       loopback_en_i,            // Wrap path active
    input  wire logic [1:0] fail_sel_i,               // Channels to fail
    output logic            primary_channel_fail_o,   // Primary mismatch
    output logic            secondary_channel_fail_o  // Secondary mismatch
);
    // --------
    // Decoders
    // --------
    logic tog = 1'b0;
    // Lines wander outside the test, so the design must not sample them then
    always @(posedge mclk_i) tog <= ~tog;
    assign primary_channel_fail_o   = loopback_en_i ? fail_sel_i[0] : tog;
    assign secondary_channel_fail_o = loopback_en_i ? fail_sel_i[1] : ~tog;
endmodule

// File: tb_top.sv
// Self-checking bench for the test/reset/monitor register bank
`timescale 1ns/1ps
module tb_top;
    logic mclk_i = 1'b0, rst_n_i = 1'b0, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0, bc = 1'b0;
    logic [7:0] awa = 8'h00, ara = 8'h00, tt;
    logic [31:0] wd = 32'h0, rdat, ms;
    logic [1:0] fs = 2'b00, br, rr;
    logic [4:0] ta;
    logic awr, wrd, bv, arr, rv, pf, sf, tf, lb, cr, ca, ch, me;
    int num_errors = 0, checked = 0, cyc = 0;
    // --------
    // Harness
    // --------
    trm_regs #(.BIT_CYC(20), .TICK_CYC(16)) uut (.mclk_i, .rst_n_i, .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
        .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd),
        .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bre), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
        .s_axi_arready_o(arr), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rre),
        .terminal_address_inputs_i(5'h15), .primary_channel_fail_i(pf), .secondary_channel_fail_i(sf),
        .bus_command_i(bc), .terminal_fail_out_o(tf), .loopback_en_o(lb), .codec_reset_o(cr), .cmd_accept_o(ca),
        .cmd_halt_o(ch), .monitor_en_o(me), .monitor_sel_o(ms), .terminal_address_o(ta), .time_tag_o(tt));
    trm_loop_model lm (.mclk_i, .loopback_en_i(lb), .fail_sel_i(fs), .primary_channel_fail_o(pf),
        .secondary_channel_fail_o(sf));
    initial forever #5 mclk_i = ~mclk_i;
    // Run should take about 430 cycles
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            results();
        end
    end
    task results();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task ck(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("FAIL %0t got %h want %h", $time, g, e);
        end
    endtask
    task wr(input logic [4:0] i, input logic [15:0] v);
        @(posedge mclk_i);
        awa <= {1'b0, i, 2'b00};
        wd  <= {16'h0000, v};
        awv <= 1'b1;
        wv  <= 1'b1;
        bre <= 1'b1;
        do begin
            @(posedge mclk_i);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
        end while (bv !== 1'b1);
        bre <= 1'b0;
        #1;
        ck(32'(br), 32'h0);
    endtask
    task rc(input logic [4:0] i, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
        @(posedge mclk_i);
        ara <= {1'b0, i, 2'b00};
        arv <= 1'b1;
        rre <= 1'b1;
        do @(posedge mclk_i); while (rv !== 1'b1);
        arv <= 1'b0;
        rre <= 1'b0;
        #1;
        ck(rdat & m, e);
        ck(32'(rr), 32'(er));
    endtask
    task cmd(input logic e);
        @(posedge mclk_i);
        bc <= 1'b1;
        @(posedge mclk_i);
        bc <= 1'b0;
        #1 ck(32'(ca), 32'(e));
    endtask
    // --------
    // Tests
    // --------
    initial begin
        repeat (20) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        ck(32'(ta), 32'h15);
        rc(trm_pkg::IDX_RTADDR, 32'h1f, 32'h15, trm_pkg::RESP_OKAY);
        wr(trm_pkg::IDX_RTADDR, 16'h0007);
        ck(32'(ta), 32'h07);
        rc(5'h13, 32'hffffffff, 32'h0, trm_pkg::RESP_SLVERR);
        wr(trm_pkg::IDX_MONLO, 16'h0020);
        wr(trm_pkg::IDX_MONHI, 16'h0021);
        wr(trm_pkg::IDX_MODE, 16'ha000);
        ck(ms, 32'h00210020);
        ck(32'(me), 32'h1);
        wr(trm_pkg::IDX_MODE, 16'hc000);
        ck(ms, 32'hffffffff);
        wr(trm_pkg::IDX_CTRL, 16'h0400);
        ck(32'(me), 32'h0);
        wr(trm_pkg::IDX_CTRL, 16'h0000);
        wr(trm_pkg::IDX_MODE, 16'h0000);
        cmd(1'b1);
        wr(trm_pkg::IDX_TTRST, 16'h5a5a);
        repeat (8) @(posedge mclk_i);
        ck(32'(tt), 32'h0);
        repeat (16) @(posedge mclk_i);
        ck(32'(tt), 32'h1);
        for (int k = 1; k < 3; k++) begin
            fs <= 2'(k);
            wr(trm_pkg::IDX_PRST, 16'h1234);
            ck(32'(cr), 32'h1);
            ck(32'(ch), 32'h1);
            rc(trm_pkg::IDX_MONLO, 32'hffff, 32'h20, trm_pkg::RESP_OKAY);
            repeat (110) @(posedge mclk_i);
            wr(trm_pkg::IDX_BITSTART, 16'hffff);
            rc(trm_pkg::IDX_STAT, 32'h8000, 32'h8000, trm_pkg::RESP_OKAY);
            ck(32'(lb), 32'h1);
            cmd(1'b0);
            repeat (40) @(posedge mclk_i);
            rc(trm_pkg::IDX_BITRES, 32'hc000, 32'(k) << 14, trm_pkg::RESP_OKAY);
            ck(32'(tf), 32'h1);
            ck(32'(lb), 32'h0);
        end
        results();
    end
endmodule
